// *** hdl/siu_defines.vh ***
/*
 constants of the system instruction unit: states, operation codes,
 register offsets, frame layout, bit positions and fault codes.
 assumes inclusion by the unit's module, its property checker and its bench.
*/
`ifndef SIU_DEFINES_VH
`define SIU_DEFINES_VH
// states
`define ST_IDLE 4'h0
`define ST_RD_ENT 4'h1
`define ST_WR_PFP 4'h2
`define ST_WR_RIP 4'h3
`define ST_RD_PFP 4'h4
`define ST_RD_RIP 4'h5
`define ST_AT_RD 4'h6
`define ST_AT_WR 4'h7
`define ST_FLUSH 4'h8
`define ST_SYNC 4'h9
// operation codes on op_code
`define OP_CALL 5'h00
`define OP_CALLX 5'h01
`define OP_CALLS 5'h02
`define OP_RET 5'h03
`define OP_FAULT 5'h04
`define OP_SYNCF 5'h05
`define OP_MARK 5'h06
`define OP_FMARK 5'h07
`define OP_MODTC 5'h08
`define OP_ATADD 5'h09
`define OP_ATMOD 5'h0A
`define OP_MODPC 5'h0B
`define OP_FLUSH 5'h0C
`define OP_MODAC 5'h0D
`define OP_SYSCTL 5'h0E
`define OP_ICCTL 5'h0F
`define OP_DCCTL 5'h10
`define OP_DCINVA 5'h11
// register offsets
`define A_PROC 8'h00
`define A_TRACE 8'h04
`define A_ARITH 8'h08
`define A_SYSTAB 8'h0C
`define A_SSP 8'h10
`define A_FP 8'h14
`define A_STAT 8'h18
// frame and table layout
`define FRAME_SIZE 32'h00000040
`define RIP_OFF 32'h00000004
`define SAVE_OFF 32'h00000008
`define ENT_BASE 32'h00000030
`define ENT_SUP 2'h2
`define NSETS 3'h4
// bit positions and reset values
`define MODE_BIT 1
`define BRK_EN 7
`define BRK_FLAG 23
`define RST_PROC 32'h00000002
`define RST_ZERO 32'h00000000
// fault codes and cache subfunctions
`define FLT_COND 4'h1
`define FLT_PRIV 4'h2
`define FLT_OPER 4'h3
`define CACHE_LOCK 3'h3
`define CACHE_INVA_Q 3'h7
`endif

// *** hdl/system_instruction_unit.v ***
/*
 system instruction unit: executes call and return, conditional
 faults, fault sync, trace marks, atomics, control register modify,
 register flush, system control and cache control operations.
 assumes a decoder presenting one operation with operands, a memory
 answering each held request with a one-cycle ack, and a plain
 register port with read data one cycle after the strobe.
*/
// Overview of operation
// - direct call target is call address plus signed displacement
// - extended call target is the run-time absolute address
// - local calls allocate new register set and frame, same stack
// - system call reads target from table entry chosen by index
// - supervisor entry switches to supervisor mode and stack
// - local-type system entry keeps mode and stack unchanged
// - return resumes at saved return address, for every call kind
// - conditional fault raised only when condition code matches
// - prediction bit is only a hint, never changes result
// - fault sync waits until earlier faults are signalled
// - mark gives breakpoint event only when breakpoint trace enabled
// - forced mark always gives breakpoint event
// - trace register holds enables and event flags, modify alters it
// - atomic read and write form one locked memory sequence
// - atomic add writes back memory value plus operand
// - atomic modify replaces only mask-selected bits
// - process register readable always, writable only in supervisor
// - flush writes all non-current register sets to their frames
// - arithmetic modify returns register and updates under mask
// - system control acts only in supervisor mode
// - cache control ops; locking only for instruction cache
// - data cache invalidate targets exactly one quad word
`include "siu_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module system_instruction_unit (
  input wire ref_clk,
  input wire reset_n,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [31:0] op_ip,
  input wire [23:0] op_disp,
  input wire [31:0] op_ea,
  input wire [31:0] op_src1,
  input wire [31:0] op_src2,
  input wire [2:0] op_cond,
  input wire op_hint,
  input wire fault_pending,
  output wire op_ready,
  output reg op_done,
  output reg [31:0] op_result,
  output reg fault_out,
  output reg [3:0] fault_code,
  output reg trace_brk,
  output reg ip_load,
  output reg [31:0] ip_next,
  output reg mem_req,
  output reg mem_we,
  output reg mem_lock,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  output reg sysctl_strobe,
  output reg [31:0] sysctl_msg,
  output reg icache_strobe,
  output reg dcache_strobe,
  output reg [2:0] cache_cmd,
  output reg [31:0] cache_addr,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

  // masked merge used by every modify operation
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  reg rst_s1_q;
  reg rst_n_q;
  wire rst_n;
  reg [3:0] state_q;
  reg [31:0] proc_ctl_q;
  reg [31:0] trace_ctl_q;
  reg [31:0] arith_ctl_q;
  reg [31:0] systab_q;
  reg [31:0] ssp_q;
  reg [31:0] fp_q;
  reg [31:0] nfp_q;
  reg [31:0] tgt_q;
  reg [31:0] rip_q;
  reg [31:0] pfp_q;
  reg [31:0] src_q;
  reg [31:0] mask_q;
  reg at_add_q;
  reg new_sup_q;
  reg [2:0] depth_q;
  reg [31:0] set_fp [0:3];
  reg [31:0] set_lnk [0:3];
  wire take;
  wire sup;
  wire [2:0] cc;
  wire cond_hit;
  wire brk_set;
  wire [31:0] disp_ext;
  wire [31:0] ent_addr;
  wire [1:0] top;

  // reset release through two flops
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_n_q;

  // operation acceptance and decoded helpers
  assign op_ready = (state_q == `ST_IDLE) && rst_n;
  assign take = op_valid && op_ready;
  assign sup = proc_ctl_q[`MODE_BIT];
  assign cc = arith_ctl_q[2:0];
  assign cond_hit = (op_cond == 3'h0) ? (cc == 3'h0) : |(op_cond & cc);
  assign brk_set = take && ((op_code == `OP_MARK && trace_ctl_q[`BRK_EN])
                   || op_code == `OP_FMARK);
  assign disp_ext = {{8{op_disp[23]}}, op_disp};
  assign ent_addr = systab_q + `ENT_BASE + {op_src1[29:0], 2'h0};
  assign top = depth_q[1:0] - 2'h1;

  // register read port, data one cycle after strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `RST_ZERO;
    end else if (reg_rd) begin
      if (reg_addr == `A_PROC) begin
        reg_rdata <= proc_ctl_q;
      end else if (reg_addr == `A_TRACE) begin
        reg_rdata <= trace_ctl_q;
      end else if (reg_addr == `A_ARITH) begin
        reg_rdata <= arith_ctl_q;
      end else if (reg_addr == `A_SYSTAB) begin
        reg_rdata <= systab_q;
      end else if (reg_addr == `A_SSP) begin
        reg_rdata <= ssp_q;
      end else if (reg_addr == `A_FP) begin
        reg_rdata <= fp_q;
      end else if (reg_addr == `A_STAT) begin
        reg_rdata <= {25'h0000000, depth_q, state_q};
      end else begin
        reg_rdata <= `RST_ZERO;
      end
    end else begin
      reg_rdata <= `RST_ZERO;
    end
  end

  // cached register set linkage stack
  always @(posedge ref_clk) begin
    if (state_q == `ST_WR_RIP && mem_ack && depth_q != `NSETS) begin
      set_fp[depth_q[1:0]] <= fp_q;
      set_lnk[depth_q[1:0]] <= pfp_q;
    end
  end

  // execution sequencer and control registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= `ST_IDLE;
      proc_ctl_q <= `RST_PROC;
      trace_ctl_q <= `RST_ZERO;
      arith_ctl_q <= `RST_ZERO;
      systab_q <= `RST_ZERO;
      ssp_q <= `RST_ZERO;
      fp_q <= `RST_ZERO;
      nfp_q <= `RST_ZERO;
      tgt_q <= `RST_ZERO;
      rip_q <= `RST_ZERO;
      pfp_q <= `RST_ZERO;
      src_q <= `RST_ZERO;
      mask_q <= `RST_ZERO;
      at_add_q <= 1'b0;
      new_sup_q <= 1'b0;
      depth_q <= 3'h0;
      op_done <= 1'b0;
      op_result <= `RST_ZERO;
      fault_out <= 1'b0;
      fault_code <= 4'h0;
      trace_brk <= 1'b0;
      ip_load <= 1'b0;
      ip_next <= `RST_ZERO;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_lock <= 1'b0;
      mem_addr <= `RST_ZERO;
      mem_wdata <= `RST_ZERO;
      sysctl_strobe <= 1'b0;
      sysctl_msg <= `RST_ZERO;
      icache_strobe <= 1'b0;
      dcache_strobe <= 1'b0;
      cache_cmd <= 3'h0;
      cache_addr <= `RST_ZERO;
    end else begin
      op_done <= 1'b0;
      fault_out <= 1'b0;
      trace_brk <= brk_set;
      ip_load <= 1'b0;
      sysctl_strobe <= 1'b0;
      icache_strobe <= 1'b0;
      dcache_strobe <= 1'b0;
      // register port writes; instruction effects below override
      if (reg_wr) begin
        if (reg_addr == `A_PROC && sup) begin
          proc_ctl_q <= reg_wdata;
        end else if (reg_addr == `A_TRACE) begin
          trace_ctl_q <= reg_wdata;
        end else if (reg_addr == `A_ARITH) begin
          arith_ctl_q <= reg_wdata;
        end else if (reg_addr == `A_SYSTAB) begin
          systab_q <= reg_wdata;
        end else if (reg_addr == `A_SSP) begin
          ssp_q <= reg_wdata;
        end else if (reg_addr == `A_FP) begin
          fp_q <= reg_wdata;
        end
      end
      case (state_q)
        `ST_IDLE: begin
          if (take) begin
            rip_q <= op_ip + `RIP_OFF;
            pfp_q <= {fp_q[31:1], sup};
            if (op_code == `OP_CALL || op_code == `OP_CALLX) begin
              tgt_q <= (op_code == `OP_CALL) ? op_ip + disp_ext : op_ea;
              nfp_q <= fp_q + `FRAME_SIZE;
              new_sup_q <= sup;
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= fp_q + `FRAME_SIZE;
              mem_wdata <= {fp_q[31:1], sup};
              state_q <= `ST_WR_PFP;
            end else if (op_code == `OP_CALLS) begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= ent_addr;
              state_q <= `ST_RD_ENT;
            end else if (op_code == `OP_RET) begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= fp_q;
              state_q <= `ST_RD_PFP;
            end else if (op_code == `OP_FAULT) begin
              if (cond_hit) begin
                fault_out <= 1'b1;
                fault_code <= `FLT_COND;
              end
              op_done <= 1'b1;
            end else if (op_code == `OP_SYNCF) begin
              state_q <= `ST_SYNC;
            end else if (op_code == `OP_MODTC) begin
              op_result <= trace_ctl_q;
              trace_ctl_q <= merge(trace_ctl_q, op_src2, op_src1);
              op_done <= 1'b1;
            end else if (op_code == `OP_ATADD || op_code == `OP_ATMOD) begin
              // lock held over read and write
              at_add_q <= (op_code == `OP_ATADD);
              src_q <= op_src2;
              mask_q <= op_src1;
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_lock <= 1'b1;
              mem_addr <= op_ea;
              state_q <= `ST_AT_RD;
            end else if (op_code == `OP_MODPC) begin
              op_result <= proc_ctl_q;
              if (op_src1 != `RST_ZERO && !sup) begin
                fault_out <= 1'b1;
                fault_code <= `FLT_PRIV;
              end else begin
                proc_ctl_q <= merge(proc_ctl_q, op_src2, op_src1);
              end
              op_done <= 1'b1;
            end else if (op_code == `OP_FLUSH) begin
              state_q <= `ST_FLUSH;
            end else if (op_code == `OP_MODAC) begin
              op_result <= arith_ctl_q;
              arith_ctl_q <= merge(arith_ctl_q, op_src2, op_src1);
              op_done <= 1'b1;
            end else if (op_code == `OP_SYSCTL) begin
              if (sup) begin
                sysctl_strobe <= 1'b1;
                sysctl_msg <= op_src1;
              end else begin
                fault_out <= 1'b1;
                fault_code <= `FLT_PRIV;
              end
              op_done <= 1'b1;
            end else if (op_code == `OP_ICCTL) begin
              icache_strobe <= 1'b1;
              cache_cmd <= op_src1[2:0];
              cache_addr <= op_src2;
              op_done <= 1'b1;
            end else if (op_code == `OP_DCCTL) begin
              if (op_src1[2:0] == `CACHE_LOCK) begin
                fault_out <= 1'b1;
                fault_code <= `FLT_OPER;
              end else begin
                dcache_strobe <= 1'b1;
                cache_cmd <= op_src1[2:0];
                cache_addr <= op_src2;
              end
              op_done <= 1'b1;
            end else if (op_code == `OP_DCINVA) begin
              dcache_strobe <= 1'b1;
              cache_cmd <= `CACHE_INVA_Q;
              cache_addr <= {op_ea[31:4], 4'h0};
              op_done <= 1'b1;
            end else begin
              op_done <= 1'b1;
            end
          end
        end
        `ST_RD_ENT: begin
          if (mem_ack) begin
            tgt_q <= {mem_rdata[31:2], 2'h0};
            mem_we <= 1'b1;
            if (mem_rdata[1:0] == `ENT_SUP && !sup) begin
              nfp_q <= ssp_q;
              new_sup_q <= 1'b1;
              mem_addr <= ssp_q;
            end else begin
              nfp_q <= fp_q + `FRAME_SIZE;
              new_sup_q <= sup;
              mem_addr <= fp_q + `FRAME_SIZE;
            end
            mem_wdata <= pfp_q;
            state_q <= `ST_WR_PFP;
          end
        end
        `ST_WR_PFP: begin
          if (mem_ack) begin
            mem_addr <= nfp_q + `RIP_OFF;
            mem_wdata <= rip_q;
            state_q <= `ST_WR_RIP;
          end
        end
        `ST_WR_RIP: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            fp_q <= nfp_q;
            proc_ctl_q[`MODE_BIT] <= new_sup_q;
            if (depth_q != `NSETS) begin
              depth_q <= depth_q + 3'h1;
            end
            ip_next <= tgt_q;
            ip_load <= 1'b1;
            op_done <= 1'b1;
            state_q <= `ST_IDLE;
          end
        end
        `ST_RD_PFP: begin
          if (mem_ack) begin
            pfp_q <= mem_rdata;
            mem_addr <= fp_q + `RIP_OFF;
            state_q <= `ST_RD_RIP;
          end
        end
        `ST_RD_RIP: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            fp_q <= {pfp_q[31:1], 1'b0};
            proc_ctl_q[`MODE_BIT] <= pfp_q[0] & sup;
            if (depth_q != 3'h0) begin
              depth_q <= depth_q - 3'h1;
            end
            ip_next <= mem_rdata;
            ip_load <= 1'b1;
            op_done <= 1'b1;
            state_q <= `ST_IDLE;
          end
        end
        `ST_AT_RD: begin
          if (mem_ack) begin
            op_result <= mem_rdata;
            mem_we <= 1'b1;
            mem_wdata <= at_add_q ? mem_rdata + src_q
                         : merge(mem_rdata, src_q, mask_q);
            state_q <= `ST_AT_WR;
          end
        end
        `ST_AT_WR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            op_done <= 1'b1;
            state_q <= `ST_IDLE;
          end
        end
        `ST_FLUSH: begin
          // one save write per non-current set
          if (depth_q == 3'h0) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            op_done <= 1'b1;
            state_q <= `ST_IDLE;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= set_fp[top] + `SAVE_OFF;
            mem_wdata <= set_lnk[top];
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            depth_q <= depth_q - 3'h1;
          end
        end
        `ST_SYNC: begin
          if (!fault_pending) begin
            op_done <= 1'b1;
            state_q <= `ST_IDLE;
          end
        end
        default: begin
          state_q <= `ST_IDLE;
        end
      endcase
      // event flag set wins over any clear
      if (brk_set) begin
        trace_ctl_q[`BRK_FLAG] <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/siu_properties.sv ***
/*
 checker of the system instruction unit's ports: call targets, fault
 sync, marks, locked atomics and cache commands.
 assumes the unit's defines header and a bind onto the unit.
*/
`include "siu_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module siu_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire logic [4:0] op_code,
  input wire logic [31:0] op_ip,
  input wire logic [23:0] op_disp,
  input wire logic [31:0] op_ea,
  input wire logic [31:0] op_src1,
  input wire logic [31:0] op_src2,
  input wire logic fault_pending,
  input wire logic op_done,
  input wire logic fault_out,
  input wire logic [3:0] fault_code,
  input wire logic trace_brk,
  input wire logic ip_load,
  input wire logic [31:0] ip_next,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_lock,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic [31:0] mem_wdata,
  input wire logic dcache_strobe,
  input wire logic [2:0] cache_cmd,
  input wire logic [31:0] cache_addr
);
  logic [4:0] code_q;
  logic [31:0] tgt_q, ea_q, s1_q, s2_q;
  wire take = op_valid && op_ready;
  // keep the operands of the operation last taken
  always @(posedge ref_clk) begin
    if (take) begin
      code_q <= op_code;
      tgt_q <= op_ip + {{8{op_disp[23]}}, op_disp};
      ea_q <= op_ea;
      s1_q <= op_src1;
      s2_q <= op_src2;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence at_rd;
    mem_lock && mem_ack && !mem_we;
  endsequence
  call_target_a: assert property (
    ip_load && code_q == `OP_CALL |-> ip_next == tgt_q)
    else $error("call target wrong");
  callx_target_a: assert property (
    ip_load && code_q == `OP_CALLX |-> ip_next == ea_q)
    else $error("extended call target wrong");
  sync_wait_a: assert property (
    op_done && code_q == `OP_SYNCF |-> !$past(fault_pending))
    else $error("fault sync ended while faults pending");
  forced_mark_a: assert property (
    take && op_code == `OP_FMARK |=> trace_brk && op_done)
    else $error("forced mark gave no event");
  lock_held_a: assert property (
    at_rd |=> mem_lock && mem_req && mem_we)
    else $error("atomic write not locked");
  lock_end_a: assert property (
    $fell(mem_lock) |-> $past(mem_ack && mem_we))
    else $error("lock dropped before write ack");
  add_sum_a: assert property (
    at_rd and code_q == `OP_ATADD |=> mem_wdata == $past(mem_rdata) + s2_q)
    else $error("atomic add sum wrong");
  mod_mask_a: assert property (
    at_rd and code_q == `OP_ATMOD
    |=> mem_wdata == (($past(mem_rdata) & ~s1_q) | (s2_q & s1_q)))
    else $error("atomic modify merge wrong");
  dlock_refused_a: assert property (
    take && op_code == `OP_DCCTL && op_src1 == 32'h00000003
    |=> fault_out && fault_code == `FLT_OPER && !dcache_strobe)
    else $error("data cache lock not refused");
  quad_inva_a: assert property (
    take && op_code == `OP_DCINVA |=> dcache_strobe
    && cache_cmd == `CACHE_INVA_Q && cache_addr[31:4] == ea_q[31:4])
    else $error("quad invalidate wrong");
endmodule
bind system_instruction_unit siu_properties i_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .op_valid(op_valid),
  .op_ready(op_ready), .op_code(op_code), .op_ip(op_ip),
  .op_disp(op_disp), .op_ea(op_ea), .op_src1(op_src1),
  .op_src2(op_src2), .fault_pending(fault_pending), .op_done(op_done),
  .fault_out(fault_out), .fault_code(fault_code), .trace_brk(trace_brk),
  .ip_load(ip_load), .ip_next(ip_next), .mem_req(mem_req),
  .mem_we(mem_we), .mem_lock(mem_lock), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
  .dcache_strobe(dcache_strobe), .cache_cmd(cache_cmd),
  .cache_addr(cache_addr));
`default_nettype wire

// *** bench/mem_model.sv ***
/*
 memory behind the unit: 256 words, answers a held request with a
 one-cycle ack after lag idle cycles.
 assumes requests held until ack.
*/
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic ref_clk,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] lag,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [0:255];
  logic [1:0] cnt_q;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    cnt_q = 2'h0;
  end
  // read data is garbled outside the ack cycle
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && cnt_q == lag) begin
      mem_ack <= 1'b1;
      cnt_q <= 2'h0;
      if (mem_we)
        mem[mem_addr[9:2]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[9:2]];
    end else if (mem_req && !mem_ack) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_system_instruction_unit.sv ***
/*
 bench of the system instruction unit: operation and register tasks.
 assumes the unit's defines header and the memory model.
*/
`include "siu_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_system_instruction_unit;
  logic ref_clk, reset_n, op_valid, op_hint, fault_pending, reg_wr, reg_rd;
  logic [4:0] op_code;
  logic [2:0] op_cond, cc;
  logic [23:0] op_disp;
  logic [7:0] reg_addr;
  logic [1:0] lag;
  logic [31:0] op_ip, op_ea, op_src1, op_src2, reg_wdata;
  wire op_ready, op_done, fault_out, trace_brk, ip_load, mem_req, mem_we;
  wire mem_lock, mem_ack, sysctl_strobe, icache_strobe, dcache_strobe;
  wire [3:0] fault_code;
  wire [2:0] cache_cmd;
  wire [31:0] op_result, ip_next, mem_addr, mem_wdata, mem_rdata;
  wire [31:0] sysctl_msg, cache_addr, reg_rdata;
  int fails = 0;
  int n_checks = 0;
  int n_flt = 0;
  int n_brk = 0;
  int n_done = 0;
  int n_sys = 0;
  int n_dc = 0;
  int n_ic = 0;
  int n0;
  system_instruction_unit i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .op_ip(op_ip), .op_disp(op_disp), .op_ea(op_ea),
    .op_src1(op_src1), .op_src2(op_src2), .op_cond(op_cond),
    .op_hint(op_hint), .fault_pending(fault_pending), .op_ready(op_ready),
    .op_done(op_done), .op_result(op_result), .fault_out(fault_out),
    .fault_code(fault_code), .trace_brk(trace_brk), .ip_load(ip_load),
    .ip_next(ip_next), .mem_req(mem_req), .mem_we(mem_we),
    .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .sysctl_strobe(sysctl_strobe), .sysctl_msg(sysctl_msg),
    .icache_strobe(icache_strobe), .dcache_strobe(dcache_strobe),
    .cache_cmd(cache_cmd), .cache_addr(cache_addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  mem_model i_mem (
    .ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lag(lag),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // count the unit's one-cycle pulses
  always @(posedge ref_clk) begin
    n_flt += int'(fault_out === 1'b1);
    n_brk += int'(trace_brk === 1'b1);
    n_done += int'(op_done === 1'b1);
    n_sys += int'(sysctl_strobe === 1'b1);
    n_dc += int'(dcache_strobe === 1'b1);
    n_ic += int'(icache_strobe === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic go(input logic [4:0] c, input logic [31:0] a, s1, s2);
    int n;
    op_code <= c;
    op_ea <= a;
    op_src1 <= s1;
    op_src2 <= s2;
    op_valid <= 1'b1;
    do @(posedge ref_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (op_done !== 1'b1 && n < 99);
    if (n >= 99)
      chk("op_done", 1, 0);
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk(nm, e, reg_rdata);
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
  initial begin
    {reset_n, op_valid, op_hint, fault_pending, reg_wr, reg_rd} = 6'h00;
    {op_code, op_cond, op_disp, reg_addr, lag} = 42'h0;
    {op_ip, op_ea, op_src1, op_src2, reg_wdata} = 160'h0;
    i_mem.mem[8'h20] = 32'hA;
    i_mem.mem[8'h21] = 32'hF0F0;
    i_mem.mem[8'h8D] = 32'h5002;
    i_mem.mem[8'h8E] = 32'h6000;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`A_PROC, `RST_PROC, "proc");
    rd(8'h40, 0, "unmapped");
    wr(`A_FP, 32'h100);
    wr(`A_SYSTAB, 32'h200);
    wr(`A_SSP, 32'h300);
    wr(`A_ARITH, 32'h5);
    go(`OP_MODAC, 0, 32'h3, 32'h2);
    chk("modac old", 32'h5, op_result);
    rd(`A_ARITH, 32'h6, "arith");
    for (int k = 0; k < 32; k++) begin
      cc = (k < 8) ? 3'h0 : 3'h1 << (k / 8 - 1);
      wr(`A_ARITH, {29'h0, cc});
      op_cond <= k[2:0];
      op_hint <= k[0] ^ k[3];
      n0 = n_flt;
      go(`OP_FAULT, 0, 0, 0);
      chk("fault", (k[2:0] == 0) ? cc == 0 : |(k[2:0] & cc), n_flt - n0);
      if (n_flt > n0)
        chk("fault code", `FLT_COND, fault_code);
    end
    n0 = n_brk;
    go(`OP_MARK, 0, 0, 0);
    chk("mark off", n0, n_brk);
    wr(`A_TRACE, 32'h80);
    go(`OP_MARK, 0, 0, 0);
    chk("mark on", n0 + 1, n_brk);
    rd(`A_TRACE, 32'h00800080, "trace flag");
    go(`OP_MODTC, 0, 32'h80, 32'h0);
    chk("modtc old", 32'h00800080, op_result);
    rd(`A_TRACE, 32'h00800000, "trace");
    go(`OP_FMARK, 0, 0, 0);
    chk("fmark", n0 + 2, n_brk);
    op_ip <= 32'h1000;
    op_disp <= 24'hFFFFF0;
    go(`OP_CALL, 0, 0, 0);
    chk("call ip", 32'h0FF0, ip_next);
    chk("link", 32'h101, i_mem.mem[8'h50]);
    chk("rip", 32'h1004, i_mem.mem[8'h51]);
    rd(`A_FP, 32'h140, "fp");
    op_ip <= 32'h2000;
    lag <= 2'h2;
    go(`OP_CALLX, 32'h2468, 0, 0);
    chk("callx ip", 32'h2468, ip_next);
    go(`OP_RET, 0, 0, 0);
    chk("ret ip", 32'h2004, ip_next);
    rd(`A_FP, 32'h140, "fp");
    wr(`A_PROC, 0);
    wr(`A_PROC, 32'h2);
    rd(`A_PROC, 0, "proc");
    n0 = n_flt;
    go(`OP_MODPC, 0, 32'h2, 32'h2);
    go(`OP_SYSCTL, 0, 32'h77, 0);
    chk("priv faults", n0 + 2, n_flt);
    chk("priv code", `FLT_PRIV, fault_code);
    chk("sysctl user", 0, n_sys);
    rd(`A_PROC, 0, "proc");
    go(`OP_CALLS, 0, 32'h2, 0);
    chk("calls local", 32'h6000, ip_next);
    rd(`A_FP, 32'h180, "fp");
    rd(`A_PROC, 0, "proc");
    go(`OP_CALLS, 0, 32'h1, 0);
    chk("calls sup", 32'h5000, ip_next);
    rd(`A_FP, 32'h300, "fp");
    rd(`A_PROC, 32'h2, "proc");
    chk("sup link", 32'h180, i_mem.mem[8'hC0]);
    go(`OP_SYSCTL, 0, 32'h77, 0);
    chk("sysctl sup", 1, n_sys);
    chk("sysctl msg", 32'h77, sysctl_msg);
    go(`OP_RET, 0, 0, 0);
    chk("ret sup ip", 32'h2004, ip_next);
    rd(`A_PROC, 0, "proc");
    rd(`A_STAT, 32'h20, "depth");
    go(`OP_FLUSH, 0, 0, 0);
    chk("flush", 32'h101, i_mem.mem[8'h42]);
    rd(`A_STAT, 0, "depth");
    fault_pending <= 1'b1;
    n0 = n_done;
    fork
      go(`OP_SYNCF, 0, 0, 0);
      begin
        repeat (6) @(posedge ref_clk);
        chk("syncf wait", n0, n_done);
        fault_pending <= 1'b0;
      end
    join
    go(`OP_ATADD, 32'h80, 0, 32'h5);
    chk("atadd old", 32'hA, op_result);
    chk("atadd mem", 32'hF, i_mem.mem[8'h20]);
    lag <= 2'h0;
    go(`OP_ATMOD, 32'h84, 32'hFF, 32'h1234);
    chk("atmod mem", 32'hF034, i_mem.mem[8'h21]);
    for (int k = 0; k < 7; k++) begin
      n0 = n_dc;
      go(`OP_DCCTL, 0, k, 32'h40);
      chk("dcctl", k != 3, n_dc - n0);
      if (k != 3)
        chk("dc cmd", k, cache_cmd);
    end
    go(`OP_ICCTL, 0, `CACHE_LOCK, 0);
    chk("ic lock", `CACHE_LOCK, cache_cmd);
    chk("ic strobe", 1, n_ic);
    go(`OP_DCINVA, 32'h1238, 0, 0);
    chk("inva", 32'h123, cache_addr[31:4]);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`A_PROC, `RST_PROC, "proc again");
    print_verdict();
  end
endmodule
`default_nettype wire
